// ### core/szm_params.svh
// Register map, field layout, reset values and timing figures of the fault monitor
`ifndef SZM_PARAMS_SVH
`define SZM_PARAMS_SVH
`define SZM_IDX_SAGTIME   10'h08E
`define SZM_IDX_SAGLVL    10'h08F
`define SZM_IDX_FLAGS     10'h054
`define SZM_IDX_ENABLE    10'h058
`define SZM_SAGTIME_RST   24'h04FFFF
`define SZM_SAGLVL_RST    24'h100009
`define SZM_FLAGS_RST     6'h00
`define SZM_ENABLE_RST    6'h00
`define SZM_SIGN_RST      7'h00
`define SZM_DUR_HI        23
`define SZM_DUR_LO        16
`define SZM_ZXT_HI        15
`define SZM_ZXT_LO        0
`define SZM_LVL_HI        23
`define SZM_LVL_LO        12
`define SZM_LINE_HI       11
`define SZM_LINE_LO       0
`define SZM_SAG_LSB       0
`define SZM_ZXTO_LSB      3
`define SZM_SIGN_LSB      6
`define SZM_SIGN_HI       12
`define SZM_SAG_CNT_MAX   9'h1FF
`define SZM_ZX_CNT_ONE    16'h0001
`define SZM_ZX_CNT_ZERO   16'h0000
`define SZM_SAG_STEP_NS   10000000
`define SZM_ZX_STEP_NS    70500
`define SZM_CLK_NS        8
`define SZM_RESP_OKAY     2'h0
`define SZM_RESP_SLVERR   2'h2
`endif

// ### core/szm_pkg.sv
// Types shared by the fault monitor modules
package szm_pkg;
   typedef enum logic [1:0] {
      SZM_WR_COLLECT = 2'b01,
      SZM_WR_RESP    = 2'b10
   } szm_wr_t;
   typedef enum logic [1:0] {
      SZM_RD_IDLE = 2'b01,
      SZM_RD_DATA = 2'b10
   } szm_rd_t;
endpackage : szm_pkg

// ### core/szm_tick.sv
// Free running divider giving a one-cycle enable every CYCLES clocks
module szm_tick
   import szm_pkg::*;
#(
   parameter int unsigned CYCLES = 8
)
(
   input  wire logic CLK,
   input  wire logic RST_N,
   output logic      TICK
);
   logic [23:0] count;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         count <= 24'h000000;
         TICK  <= 1'b0;
      end
      else if (count == 24'(CYCLES - 1))
      begin
         count <= 24'h000000;
         TICK  <= 1'b1;
      end
      else
      begin
         count <= count + 24'h000001;
         TICK  <= 1'b0;
      end
   end
endmodule : szm_tick

// ### core/szm_monitor.sv
// Sag and zero-crossing timeout monitor with AXI4-Lite register slave
`include "szm_params.svh"

// How it works
// - Sag flag when voltage below level too long
// - Sag duration bits 23..16, reset 04h
// - Duration step 10 ms, max 2.55 s
// - Sag level field resets to 100h
// - Line cycles resets 009h, used as plus one
// - Timeout reload bits 15..0, reset ffffh
// - Zero crossing reloads the phase timeout counter
// - Counter decrements, sets timeout flag at zero
// - Timeout flag set regardless of enable bit
// - Timeout reaches interrupt only when enabled
// - Timeout step 70.5 us, max 4.62 s
// - Timeout flags a,b,c in bits 3..5
// - Sign bits in bits 6..12, reset 0
// - Level, duration, timeout readable and writable
// - No energy accumulation while supply low
// - Sag flags a,b,c in bits 0..2
// - Interrupt low on enabled set flag
module szm_monitor
   import szm_pkg::*;
#(
   parameter int unsigned SAG_TICK_CYCLES = `SZM_SAG_STEP_NS / `SZM_CLK_NS,
   parameter int unsigned ZX_TICK_CYCLES  = `SZM_ZX_STEP_NS / `SZM_CLK_NS
)
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [23:0] V_RMS_A,
   input  wire logic [23:0] V_RMS_B,
   input  wire logic [23:0] V_RMS_C,
   input  wire logic [6:0]  SIGN_IN,
   input  wire logic        SUPPLY_LOW,
   output logic             ACCUM_EN,
   output logic [12:0]      LINE_CYCLES,
   output logic             IRQ_N
);
   szm_wr_t       wr_state;
   szm_rd_t       rd_state;
   logic          aw_full;
   logic          w_full;
   logic [11:0]   aw_addr;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          wr_fire;
   logic [9:0]    wr_idx;
   logic [23:0]   sag_time;
   logic [23:0]   sag_level;
   logic [5:0]    flags;
   logic [5:0]    enable;
   logic [6:0]    sign;
   logic [5:0]    next_flags;
   logic [5:0]    clr_flags;
   logic [2:0]    sag_event;
   logic [2:0]    zx_event;
   logic [2:0]    crossing;
   logic [2:0]    below;
   logic [2:0][8:0]  sag_cnt;
   logic [2:0][15:0] zx_cnt;
   logic [2:0][23:0] v_rms;
   logic          sag_tick;
   logic          zx_tick;
   logic          supply_meta;
   logic          supply_low;

   function automatic logic [23:0] merge(input logic [23:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [23:0] res;
      res = old;
      for (int i = 0; i < 3; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic mapped(input logic [9:0] idx);
      return idx == `SZM_IDX_SAGTIME || idx == `SZM_IDX_SAGLVL
          || idx == `SZM_IDX_FLAGS || idx == `SZM_IDX_ENABLE;
   endfunction : mapped

   // Step enables; long counts are parameters so a bench can shorten them
   szm_tick #(.CYCLES(SAG_TICK_CYCLES)) u_sag_tick
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .TICK  (sag_tick)
   );

   szm_tick #(.CYCLES(ZX_TICK_CYCLES)) u_zx_tick
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .TICK  (zx_tick)
   );

   assign v_rms   = {V_RMS_C, V_RMS_B, V_RMS_A};
   assign wr_idx  = aw_addr[11:2];
   assign wr_fire = (wr_state == SZM_WR_COLLECT) && aw_full && w_full;

   // Write channel: address and data accepted in either order
   assign S_AXI_AWREADY = (wr_state == SZM_WR_COLLECT) && !aw_full;
   assign S_AXI_WREADY  = (wr_state == SZM_WR_COLLECT) && !w_full;
   assign S_AXI_BVALID  = (wr_state == SZM_WR_RESP);
   assign S_AXI_ARREADY = (rd_state == SZM_RD_IDLE);
   assign S_AXI_RVALID  = (rd_state == SZM_RD_DATA);

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_full <= 1'b0;
         aw_addr <= 12'h000;
      end
      else if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_full <= 1'b1;
         aw_addr <= S_AXI_AWADDR;
      end
      else if (wr_fire)
      begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_full <= 1'b1;
         w_data <= S_AXI_WDATA;
         w_strb <= S_AXI_WSTRB;
      end
      else if (wr_fire)
      begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_state    <= SZM_WR_COLLECT;
         S_AXI_BRESP <= `SZM_RESP_OKAY;
      end
      else
      begin
         case (wr_state)
            SZM_WR_COLLECT:
            begin
               if (wr_fire)
               begin
                  wr_state    <= SZM_WR_RESP;
                  S_AXI_BRESP <= mapped(wr_idx) ? `SZM_RESP_OKAY : `SZM_RESP_SLVERR;
               end
            end
            SZM_WR_RESP:
               if (S_AXI_BREADY)
                  wr_state <= SZM_WR_COLLECT;
            default:
               wr_state <= SZM_WR_COLLECT;
         endcase
      end
   end

   // Configuration registers with byte lanes
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sag_time  <= `SZM_SAGTIME_RST;
         sag_level <= `SZM_SAGLVL_RST;
         enable    <= `SZM_ENABLE_RST;
      end
      else if (wr_fire)
      begin
         if (wr_idx == `SZM_IDX_SAGTIME)
            sag_time <= merge(sag_time, w_data, w_strb);
         if (wr_idx == `SZM_IDX_SAGLVL)
            sag_level <= merge(sag_level, w_data, w_strb);
         if (wr_idx == `SZM_IDX_ENABLE && w_strb[0])
            enable <= w_data[5:0];
      end
   end

   // Field holds the count minus one
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         LINE_CYCLES <= 13'h0000;
      else
         LINE_CYCLES <= {1'b0, sag_level[`SZM_LINE_HI:`SZM_LINE_LO]} + 13'h0001;
   end

   // Read channel
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_state    <= SZM_RD_IDLE;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `SZM_RESP_OKAY;
      end
      else
      begin
         case (rd_state)
            SZM_RD_IDLE:
            begin
               if (S_AXI_ARVALID)
               begin
                  rd_state    <= SZM_RD_DATA;
                  S_AXI_RRESP <= mapped(S_AXI_ARADDR[11:2]) ? `SZM_RESP_OKAY
                                                            : `SZM_RESP_SLVERR;
                  case (S_AXI_ARADDR[11:2])
                     `SZM_IDX_SAGTIME: S_AXI_RDATA <= {8'h00, sag_time};
                     `SZM_IDX_SAGLVL:  S_AXI_RDATA <= {8'h00, sag_level};
                     `SZM_IDX_FLAGS:   S_AXI_RDATA <= {19'h00000, sign, flags};
                     `SZM_IDX_ENABLE:  S_AXI_RDATA <= {26'h0000000, enable};
                     default:          S_AXI_RDATA <= 32'h00000000;
                  endcase
               end
            end
            SZM_RD_DATA:
               if (S_AXI_RREADY)
                  rd_state <= SZM_RD_IDLE;
            default:
               rd_state <= SZM_RD_IDLE;
         endcase
      end
   end

   // Supply monitor pin is asynchronous
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         supply_meta <= 1'b1;
         supply_low  <= 1'b1;
         ACCUM_EN    <= 1'b0;
      end
      else
      begin
         supply_meta <= SUPPLY_LOW;
         supply_low  <= supply_meta;
         ACCUM_EN    <= !supply_low;
      end
   end

   // Waveform signs; a voltage sign change is a zero crossing
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         sign <= `SZM_SIGN_RST;
      else
         sign <= SIGN_IN;
   end

   always_comb
   begin
      for (int p = 0; p < 3; p++)
      begin
         crossing[p] = sign[2*p] != SIGN_IN[2*p];
         below[p]    = v_rms[p][`SZM_LVL_HI:`SZM_LVL_LO]
                     < sag_level[`SZM_LVL_HI:`SZM_LVL_LO];
      end
   end

   // Sag duration counters; the 9th bit stops a second event per low period
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         sag_cnt <= '0;
      else
         for (int p = 0; p < 3; p++)
            if (!below[p])
               sag_cnt[p] <= 9'h000;
            else if (sag_tick && sag_cnt[p] != `SZM_SAG_CNT_MAX)
               sag_cnt[p] <= sag_cnt[p] + 9'h001;
   end

   // Low for more than the programmed steps
   always_comb
   begin
      for (int p = 0; p < 3; p++)
      begin
         sag_event[p] = below[p] && sag_tick && !sag_cnt[p][8]
                     && sag_cnt[p][7:0] == sag_time[`SZM_DUR_HI:`SZM_DUR_LO];
         zx_event[p]  = !crossing[p] && zx_tick && zx_cnt[p] == `SZM_ZX_CNT_ONE;
      end
   end

   // Timeout counters stop at zero until the next crossing
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         zx_cnt <= {3{16'(`SZM_SAGTIME_RST)}};
      else
         for (int p = 0; p < 3; p++)
            if (crossing[p])
               zx_cnt[p] <= sag_time[`SZM_ZXT_HI:`SZM_ZXT_LO];
            else if (zx_tick && zx_cnt[p] != `SZM_ZX_CNT_ZERO)
               zx_cnt[p] <= zx_cnt[p] - 16'h0001;
   end

   // Sticky flags, write one to clear; a new event beats the clear
   always_comb
   begin
      clr_flags = '0;
      if (wr_fire && wr_idx == `SZM_IDX_FLAGS && w_strb[0])
      begin
         clr_flags = w_data[5:0];
      end
      next_flags = flags & ~clr_flags;
      next_flags[`SZM_SAG_LSB +: 3]  = next_flags[`SZM_SAG_LSB +: 3] | sag_event;
      next_flags[`SZM_ZXTO_LSB +: 3] = next_flags[`SZM_ZXTO_LSB +: 3] | zx_event;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         flags <= `SZM_FLAGS_RST;
      else
         flags <= next_flags;
   end

   // Registered so the pin never glitches during decode
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         IRQ_N <= 1'b1;
      else
         IRQ_N <= ~|(next_flags & enable);
   end
endmodule : szm_monitor

// ### test/szm_monitor_chk.sv
// Concurrent checks on the register bus and supply gating of the monitor, with a cover on the interrupt
module szm_monitor_chk
   import szm_pkg::*;
#(
   parameter int unsigned SAG_TICK_CYCLES = 4,
   parameter int unsigned ZX_TICK_CYCLES  = 3
)
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        SUPPLY_LOW,
   input wire logic        ACCUM_EN,
   input wire logic        IRQ_N
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   chk_write_resp:
   assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
   chk_read_resp:
   assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   chk_bresp_hold:
   assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   chk_rdata_hold:
   assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
      else $error("read data dropped");
   chk_one_read:
   assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("second read accepted");
   chk_slverr_zero:
   assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
      else $error("error read returned data");
   chk_upper_zero:
   assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:24] == 8'h00)
      else $error("unused read bits set");
   chk_supply_gate:
   assert property (SUPPLY_LOW [*3] |=> !ACCUM_EN) else $error("accumulating on low supply");
   chk_supply_free:
   assert property (!SUPPLY_LOW [*4] |=> ACCUM_EN) else $error("accumulation held off");

   cover property (S_AXI_BVALID && S_AXI_BREADY);
   cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == 2'h2);
   cover property (!IRQ_N);
endmodule : szm_monitor_chk

bind szm_monitor szm_monitor_chk #(
   .SAG_TICK_CYCLES(SAG_TICK_CYCLES), .ZX_TICK_CYCLES(ZX_TICK_CYCLES)) u_chk (
   .CLK(CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .SUPPLY_LOW(SUPPLY_LOW), .ACCUM_EN(ACCUM_EN), .IRQ_N(IRQ_N));

// ### test/tb.sv
// Self-checking bench for the sag and zero-crossing timeout monitor
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, supply_low;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdat, seed, x, y;
   logic [3:0]  wstrb;
   logic [23:0] v [3];
   logic [6:0]  sign_in;
   logic [1:0]  rsp;
   wire         awready, wready, bvalid, arready, rvalid, accum_en, irq_n;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [12:0] line_cycles;
   int          error_cnt, n_tests, cyc;

   // Short ticks keep the sag and timeout counts within a few cycles
   szm_monitor #(.SAG_TICK_CYCLES(4), .ZX_TICK_CYCLES(3)) u_dut (
      .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .V_RMS_A(v[0]), .V_RMS_B(v[1]), .V_RMS_C(v[2]), .SIGN_IN(sign_in),
      .SUPPLY_LOW(supply_low), .ACCUM_EN(accum_en), .LINE_CYCLES(line_cycles),
      .IRQ_N(irq_n));

   task automatic final_report;
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : cmp

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [31:0] exp_lc(input logic [31:0] r);
      return {19'h0, r[11:0] + 13'h1};
   endfunction : exp_lc

   // Ready is sampled mid-cycle; inputs only move at rising edges so it equals the edge value
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tk;
      ta = 1'h0;
      tw = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta = ta | awready;
         tw = tw | wready;
         @(posedge clk);
         if (ta)
            awvalid <= 1'h0;
         if (tw)
            wvalid <= 1'h0;
      end
      do
      begin
         @(negedge clk);
         tk = bvalid;
         rsp = bresp;
         @(posedge clk);
      end while (!tk);
      bready <= 1'h0;
      @(posedge clk);
   endtask : wr

   // Ready for read data comes a cycle late on purpose, to stall the slave
   task automatic rd(input logic [11:0] a);
      logic t;
      araddr <= a;
      arvalid <= 1'h1;
      do
      begin
         @(negedge clk);
         t = arready;
         @(posedge clk);
      end while (!t);
      arvalid <= 1'h0;
      do
      begin
         @(negedge clk);
         t = rvalid;
         @(posedge clk);
      end while (!t);
      rready <= 1'h1;
      @(negedge clk);
      rdat = rdata;
      rsp = rresp;
      @(posedge clk);
      rready <= 1'h0;
      @(posedge clk);
   endtask : rd

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      rd(a);
      cmp(rdat, e);
      cmp(32'(rsp), 32'(r));
   endtask : rdc

   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         final_report();
      end
   end

   initial
   begin
      seed = 32'hE9921F85;
      {rst_n, awvalid, wvalid, bready, arvalid, rready, supply_low} = 7'h00;
      {awaddr, araddr, wdata, sign_in, wstrb} = 67'hF;
      v = '{24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF};
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rdc(12'h238, 32'h0004FFFF, 2'h0);
      rdc(12'h23C, 32'h00100009, 2'h0);
      rdc(12'h150, 32'h0, 2'h0);
      rdc(12'h160, 32'h0, 2'h0);
      cmp(32'(line_cycles), 32'hA);
      cmp(32'(accum_en), 32'h1);
      rdc(12'h004, 32'h0, 2'h2);
      wr(12'h004, rnd());
      cmp(32'(rsp), 32'h2);
      repeat (4)
      begin
         x = rnd() & 32'h00FFFFFF;
         wr(12'h23C, x | 32'hFF000000);
         rdc(12'h23C, x, 2'h0);
         cmp(32'(line_cycles), exp_lc(x));
         x = rnd() & 32'h00FFFFFF;
         wr(12'h238, x);
         rdc(12'h238, x, 2'h0);
         // Only the middle lane may land
         y = rnd();
         wstrb <= 4'h2;
         wr(12'h238, y);
         wstrb <= 4'hF;
         rdc(12'h238, (x & 32'hFF00FF) | (y & 32'h00FF00), 2'h0);
         x = rnd() & 32'h0000003F;
         wr(12'h160, x);
         rdc(12'h160, x, 2'h0);
         x = rnd();
         sign_in <= x[6:0];
         repeat (3) @(posedge clk);
         rd(12'h150);
         cmp(rdat & 32'h1FC0, {19'h0, x[6:0], 6'h00});
      end
      wr(12'h160, 32'h0);
      wr(12'h238, 32'h00FF0006);
      sign_in <= sign_in ^ 7'h15;
      @(posedge clk);
      wr(12'h150, 32'h3F);
      // Without reloads the counters would expire within this stretch
      repeat (8)
      begin
         sign_in <= sign_in ^ 7'h15;
         repeat (4) @(posedge clk);
      end
      rd(12'h150);
      cmp(rdat & 32'h3F, 32'h0);
      repeat (40) @(posedge clk);
      rd(12'h150);
      cmp(rdat & 32'h3F, 32'h38);
      cmp(32'(irq_n), 32'h1);
      wr(12'h160, 32'h08);
      repeat (3) @(posedge clk);
      cmp(32'(irq_n), 32'h0);
      wr(12'h150, 32'h08);
      repeat (3) @(posedge clk);
      cmp(32'(irq_n), 32'h1);
      rd(12'h150);
      cmp(rdat & 32'h3F, 32'h30);
      wr(12'h150, 32'h3F);
      wr(12'h23C, 32'h00800009);
      wr(12'h238, 32'h0002FFFF);
      for (int p = 0; p < 3; p++)
      begin
         // Lows of six cycles hold at most two ticks, one short of the three that a duration of 2 needs
         repeat (4)
         begin
            v[p] <= 24'h100000;
            repeat (6) @(posedge clk);
            v[p] <= 24'h800000;
            @(posedge clk);
         end
         rd(12'h150);
         cmp(rdat & 32'h7, 32'h0);
         v[p] <= 24'h7FFFFF;
         repeat (20) @(posedge clk);
         v[p] <= 24'hFFFFFF;
         rd(12'h150);
         cmp(rdat & 32'h7, 32'h1 << p);
         wr(12'h150, 32'h7);
      end
      supply_low <= 1'h1;
      repeat (5) @(posedge clk);
      cmp(32'(accum_en), 32'h0);
      supply_low <= 1'h0;
      repeat (5) @(posedge clk);
      cmp(32'(accum_en), 32'h1);
      final_report();
   end
endmodule : tb
